// ==== qfbs_device.sv ====
// flag bus sequencer, device end: polled and direct quadrant flag buses,
// token chain and the shared full flag
// assumes clk stands for both read and write clock, reset_n is master reset
// Functional notes
// - polled: empty quadrants 1..4 in turn, wrap
// - empty sync high only with quadrant 1
// - polled: full quadrants 1..4 in turn, wrap
// - full sync high only with quadrant 1
// - empty token pulses with final quadrant shown
// - token in loads quadrant 1 next edge
// - single device: token in looped or low
// - chain tokens ring from last to first
// - full flag shows new queue next cycle
// - write new queue only when not full
// - only owning device drives full flag
// - flag mode latched at master reset
// - direct: full strobe selects addressed quadrant
// - strobes held low until programming done
// - direct: empty strobe selects addressed quadrant
// - top three address bits match chain code
`timescale 1ns/10ps
`default_nettype none
`include "qfbs_consts.svh"

module qfbs_device #(
  parameter int QUEUES = `QFBS_QUEUES   // queues per device
) (
  input  wire logic                       clk,
  input  wire logic                       reset_n,
  input  wire logic [`QFBS_CHAIN_W-1:0]   chainPositionCode,
  input  wire logic                       chainMaster,
  input  wire logic                       programDone,
  input  wire logic [QUEUES-1:0]          almostEmptyStatus,
  input  wire logic [QUEUES-1:0]          almostFullStatus,
  input  wire logic [QUEUES-1:0]          queueFull,
  qfbs_if.device                          link
);
  import qfbs_pkg::*;

  // strap capture; the strap pins are only trusted while reset is low
  qfbs_mode_t                 flagMode;        // latched bus mode
  qfbs_mode_t                 next_flagMode;
  logic [`QFBS_CHAIN_W-1:0]   chainCode;       // latched chain position
  logic [`QFBS_CHAIN_W-1:0]   next_chainCode;
  logic                       progDoneN;       // registered done, low true
  logic                       next_progDoneN;

  // strap and programming status, next values
  always_comb begin
    next_flagMode  = flagMode;
    next_chainCode = chainCode;
    next_progDoneN = ~programDone;
    if (!reset_n) begin
      // sampled on every clock edge while master reset is low, held afterwards
      next_flagMode  = qfbs_mode_t'(link.flagModeSelect);
      next_chainCode = chainPositionCode;
      next_progDoneN = 1'b1;
    end
  end

  // strap registers
  always_ff @(posedge clk) begin
    flagMode  <= next_flagMode;
    chainCode <= next_chainCode;
    progDoneN <= next_progDoneN;
  end

  assign link.serialProgramDoneN = progDoneN;

  // both flag buses use copies of one sequencer, index 0 empty side, 1 full side
  logic [QUEUES-1:0]       sideStatus [2];   // active high status
  logic                    sideStrobe [2];   // direct quadrant strobe
  qfbs_addr_t              sideAddr   [2];   // port address
  logic                    sideTokIn  [2];   // token from previous device
  logic [`QFBS_QUAD_W-1:0] sideBusN   [2];   // registered bus, low true
  logic                    sideOe     [2];   // registered bus enable
  logic                    sideSync   [2];   // registered sync
  logic                    sideTokOut [2];   // registered token pulse

  assign sideStatus[0] = almostEmptyStatus;
  assign sideStatus[1] = almostFullStatus;
  assign sideStrobe[0] = link.almostEmptyBusStrobe;
  assign sideStrobe[1] = link.almostFullBusStrobe;
  assign sideAddr[0]   = link.readQueueAddress;
  assign sideAddr[1]   = link.writeQueueAddress;
  assign sideTokIn[0]  = link.emptyTokenIn;
  assign sideTokIn[1]  = link.fullTokenIn;

  genvar s;
  generate
    for (s = 0; s < 2; s++) begin : g_side
      logic                    own;        // holds the bus token
      logic                    next_own;
      qfbs_quad_t              quad;       // next quadrant, or selected one
      qfbs_quad_t              next_quad;
      logic [`QFBS_QUAD_W-1:0] busN;
      logic [`QFBS_QUAD_W-1:0] next_busN;
      logic                    oe;
      logic                    next_oe;
      logic                    sync;
      logic                    next_sync;
      logic                    tok;
      logic                    next_tok;
      logic                    hit;        // address names this device

      // device select on the top address bits
      assign hit = (sideAddr[s][`QFBS_CHAIN_MSB:`QFBS_CHAIN_LSB]
                    == chainCode);

      // sequencer next values
      always_comb begin
        qfbs_quad_t shown;
        shown     = `QFBS_FIRST_QUAD;
        next_own  = own;
        next_quad = quad;
        next_busN = busN;
        next_oe   = oe;
        next_sync = 1'b0;
        next_tok  = 1'b0;
        if (!reset_n) begin
          // the chain master starts with the token after reset
          next_own  = chainMaster;
          next_quad = `QFBS_FIRST_QUAD;
          next_busN = `QFBS_BUS_IDLE;
          next_oe   = 1'b0;
        end else if (flagMode == QFBS_POLLED) begin
          if (own || sideTokIn[s]) begin
            // an arriving token restarts at quadrant 1 unless this device already owns the bus
            shown     = own ? quad : `QFBS_FIRST_QUAD;
            // eight queues per quadrant, one bit each
            next_busN = ~sideStatus[s][{shown, 3'h0} +: `QFBS_QUAD_W];
            next_oe   = 1'b1;
            next_sync = (shown == `QFBS_FIRST_QUAD);
            next_quad = shown + 2'h1;
            next_own  = (shown != `QFBS_LAST_QUAD);
            next_tok  = (shown == `QFBS_LAST_QUAD);
          end else begin
            // another device in the chain owns the bus
            next_oe = 1'b0;
          end
        end else begin
          if (sideStrobe[s]) begin
            if (hit) begin
              next_quad = sideAddr[s][`QFBS_QUAD_MSB:`QFBS_QUAD_LSB];
              next_oe   = 1'b1;
            end else begin
              // strobe aimed at another device releases the bus
              next_oe   = 1'b0;
            end
          end
          // selected quadrant tracks live status every edge
          next_busN = ~sideStatus[s][{next_quad, 3'h0} +: `QFBS_QUAD_W];
        end
      end

      // sequencer registers
      always_ff @(posedge clk) begin
        own  <= next_own;
        quad <= next_quad;
        busN <= next_busN;
        oe   <= next_oe;
        sync <= next_sync;
        tok  <= next_tok;
      end

      assign sideBusN[s]   = busN;
      assign sideOe[s]     = oe;
      assign sideSync[s]   = sync;
      assign sideTokOut[s] = tok;
    end
  endgenerate

  assign link.almostEmptyBusN  = sideBusN[0];
  assign link.almostEmptyBusOe = sideOe[0];
  assign link.emptyBusSync     = sideSync[0];
  assign link.emptyTokenOut    = sideTokOut[0];
  assign link.almostFullBusN   = sideBusN[1];
  assign link.almostFullBusOe  = sideOe[1];
  assign link.fullBusSync      = sideSync[1];
  assign link.fullTokenOut     = sideTokOut[1];

  // full flag of the selected write queue
  logic [`QFBS_QUEUE_MSB:0] ffQueue;       // selected queue in this device
  logic [`QFBS_QUEUE_MSB:0] next_ffQueue;
  logic                     ffN;           // full flag, low true
  logic                     next_ffN;
  logic                     ffOe;          // owns the shared full line
  logic                     next_ffOe;
  logic                     wrHit;         // write address names us

  assign wrHit = (link.writeQueueAddress[`QFBS_CHAIN_MSB:`QFBS_CHAIN_LSB]
                  == chainCode);

  // full flag next values
  always_comb begin
    next_ffQueue = ffQueue;
    next_ffOe    = ffOe;
    if (!reset_n) begin
      next_ffQueue = '0;
      next_ffOe    = 1'b0;
    end else if (link.writeAddressEnable) begin
      // any selection moves line ownership to the addressed device
      next_ffOe = wrHit;
      if (wrHit) begin
        next_ffQueue = link.writeQueueAddress[`QFBS_QUEUE_MSB:0];
      end
    end
    // flag follows the newly selected queue from the next cycle on
    next_ffN = reset_n ? ~queueFull[next_ffQueue] : 1'b1;
  end

  // full flag registers
  always_ff @(posedge clk) begin
    ffQueue <= next_ffQueue;
    ffN     <= next_ffN;
    ffOe    <= next_ffOe;
  end

  assign link.queueFullFlagN  = ffN;
  assign link.queueFullFlagOe = ffOe;

endmodule

`default_nettype wire

// ==== qfbs_consts.svh ====
// constants shared by both ends of the queue flag bus sequencer
// assumes one clock that stands for both the read and the write clock
`ifndef QFBS_CONSTS_SVH
`define QFBS_CONSTS_SVH

`define QFBS_ADDR_W      8      // queue address width
`define QFBS_QUEUES      32     // queues held by one device
`define QFBS_QUAD_W      8      // queues per quadrant, bus width
`define QFBS_CHAIN_W     3      // chain position code width
`define QFBS_CHAIN_MSB   7      // chain code field, high bit
`define QFBS_CHAIN_LSB   5      // chain code field, low bit
`define QFBS_QUEUE_MSB   4      // queue within device, high bit
`define QFBS_QUAD_MSB    4      // quadrant field, high bit
`define QFBS_QUAD_LSB    3      // quadrant field, low bit
`define QFBS_FIRST_QUAD  2'h0   // quadrant 1
`define QFBS_LAST_QUAD   2'h3   // quadrant 4
`define QFBS_BUS_IDLE    8'hFF  // bus level with nobody driving (pull-up)

`endif

// ==== qfbs_pkg.sv ====
// types shared by both ends of the queue flag bus sequencer
// assumes qfbs_consts.svh is on the include path
`include "qfbs_consts.svh"

package qfbs_pkg;

  // flag bus operating mode, fixed at reset
  typedef enum logic {
    QFBS_DIRECT = 1'b0,
    QFBS_POLLED = 1'b1
  } qfbs_mode_t;

  // quadrant number, 0 stands for quadrant 1
  typedef logic [1:0] qfbs_quad_t;

  // queue address as seen on both ports
  typedef logic [`QFBS_ADDR_W-1:0] qfbs_addr_t;

endpackage

// ==== qfbs_if.sv ====
// link between the flag sequencing device and its controller
// assumes a pull-up on every shared line; resolves the three-state lines
`timescale 1ns/10ps
`default_nettype none
`include "qfbs_consts.svh"

interface qfbs_if;
  logic       flagModeSelect;        // strap, high selects polled
  logic [7:0] almostEmptyBusN;       // driven quadrant, active low
  logic       almostEmptyBusOe;      // device drives almost-empty bus
  logic       emptyBusSync;          // high with quadrant 1 shown
  logic       emptyTokenIn;          // token from previous device
  logic       emptyTokenOut;         // token to next device
  logic [7:0] almostFullBusN;        // driven quadrant, active low
  logic       almostFullBusOe;       // device drives almost-full bus
  logic       fullBusSync;           // high with quadrant 1 shown
  logic       fullTokenIn;           // token from previous device
  logic       fullTokenOut;          // token to next device
  logic       queueFullFlagN;        // full flag, active low
  logic       queueFullFlagOe;       // device drives full flag line
  logic       almostEmptyBusStrobe;  // direct quadrant select, read side
  logic       almostFullBusStrobe;   // direct quadrant select, write side
  logic [7:0] readQueueAddress;      // read port address
  logic [7:0] writeQueueAddress;     // write port address
  logic       writeAddressEnable;    // write queue selection
  logic       serialProgramDoneN;    // low once programming is over

  // resolved line levels, pulled high when undriven
  wire [7:0] almostEmptyLine = almostEmptyBusOe ? almostEmptyBusN
                                                : `QFBS_BUS_IDLE;
  wire [7:0] almostFullLine  = almostFullBusOe ? almostFullBusN
                                               : `QFBS_BUS_IDLE;
  wire       fullFlagLine    = queueFullFlagOe ? queueFullFlagN : 1'b1;

  modport device (
    input  flagModeSelect, emptyTokenIn, fullTokenIn,
    input  almostEmptyBusStrobe, almostFullBusStrobe,
    input  readQueueAddress, writeQueueAddress, writeAddressEnable,
    output almostEmptyBusN, almostEmptyBusOe, emptyBusSync, emptyTokenOut,
    output almostFullBusN, almostFullBusOe, fullBusSync, fullTokenOut,
    output queueFullFlagN, queueFullFlagOe, serialProgramDoneN
  );

  modport controller (
    output flagModeSelect, emptyTokenIn, fullTokenIn,
    output almostEmptyBusStrobe, almostFullBusStrobe,
    output readQueueAddress, writeQueueAddress, writeAddressEnable,
    input  emptyBusSync, emptyTokenOut, fullBusSync, fullTokenOut,
    input  almostEmptyBusOe, almostFullBusOe, serialProgramDoneN,
    input  almostEmptyLine, almostFullLine, fullFlagLine
  );
endinterface

`default_nettype wire

// ==== qfbs_controller.sv ====
// flag bus sequencer, controller end: holds the mode strap, loops tokens
// for a single device, issues selections and collects flag quadrants
// assumes one device on the link and the same clock as the device
`timescale 1ns/10ps
`default_nettype none
`include "qfbs_consts.svh"

module qfbs_controller (
  input  wire logic                     clk,
  input  wire logic                     reset_n,
  input  wire logic                     pollMode,
  input  wire logic                     writeSelReq,
  input  wire qfbs_pkg::qfbs_addr_t     writeSelAddr,
  input  wire logic                     fullQuadReq,
  input  wire qfbs_pkg::qfbs_addr_t     fullQuadAddr,
  input  wire logic                     emptyQuadReq,
  input  wire qfbs_pkg::qfbs_addr_t     emptyQuadAddr,
  output logic                          canWrite,
  output logic                          strobeRefused,
  output logic [`QFBS_QUEUES-1:0]       almostEmptySnap,
  output logic [`QFBS_QUEUES-1:0]       almostFullSnap,
  qfbs_if.controller                    link
);
  import qfbs_pkg::*;

  qfbs_mode_t  mode;           // strap held for the whole run
  qfbs_mode_t  next_mode;
  logic        wrEn;           // write queue selection pulse
  logic        next_wrEn;
  qfbs_addr_t  wrAddr;
  qfbs_addr_t  next_wrAddr;
  logic        refused;
  logic        next_refused;
  logic        reqOk;          // strobes allowed now

  // strobes only in direct mode and after programming has finished
  assign reqOk = (mode == QFBS_DIRECT) && !link.serialProgramDoneN;

  // strap and write selection next values
  always_comb begin
    next_mode    = mode;
    next_wrEn    = writeSelReq;
    next_wrAddr  = writeSelReq ? writeSelAddr : wrAddr;
    next_refused = (fullQuadReq || emptyQuadReq) && !reqOk;
    if (!reset_n) begin
      // mode latched only during reset so the strap never moves later
      next_mode    = qfbs_mode_t'(pollMode);
      next_wrEn    = 1'b0;
      next_wrAddr  = '0;
      next_refused = 1'b0;
    end
  end

  // strap and write selection registers
  always_ff @(posedge clk) begin
    mode    <= next_mode;
    wrEn    <= next_wrEn;
    wrAddr  <= next_wrAddr;
    refused <= next_refused;
  end

  assign link.flagModeSelect     = mode;
  assign link.writeAddressEnable = wrEn;
  assign strobeRefused           = refused;
  // writes to the new queue only while the shared flag reads not full
  assign canWrite = link.fullFlagLine;
  // single device: token looped back in polled mode, low in direct
  assign link.emptyTokenIn = (mode == QFBS_POLLED) && link.emptyTokenOut;
  assign link.fullTokenIn  = (mode == QFBS_POLLED) && link.fullTokenOut;

  // per side collection, index 0 empty side, 1 full side
  logic                    sReq  [2];
  qfbs_addr_t              sAddr [2];
  logic                    sSync [2];
  logic                    sOe   [2];
  logic [`QFBS_QUAD_W-1:0] sLine [2];
  logic [`QFBS_QUEUES-1:0] sSnap [2];
  logic                    sStb  [2];
  qfbs_addr_t              sAdrO [2];

  assign sReq[0]  = emptyQuadReq;
  assign sReq[1]  = fullQuadReq;
  assign sAddr[0] = emptyQuadAddr;
  assign sAddr[1] = fullQuadAddr;
  assign sSync[0] = link.emptyBusSync;
  assign sSync[1] = link.fullBusSync;
  assign sOe[0]   = link.almostEmptyBusOe;
  assign sOe[1]   = link.almostFullBusOe;
  assign sLine[0] = link.almostEmptyLine;
  assign sLine[1] = link.almostFullLine;

  genvar s;
  generate
    for (s = 0; s < 2; s++) begin : g_side
      qfbs_quad_t              idx;       // quadrant last collected; in direct mode the one now on the bus
      qfbs_quad_t              next_idx;
      logic [`QFBS_QUEUES-1:0] snap;      // collected status, high true
      logic [`QFBS_QUEUES-1:0] next_snap;
      logic                    stb;
      logic                    next_stb;
      qfbs_addr_t              adr;
      qfbs_addr_t              next_adr;

      // collector next values
      always_comb begin
        qfbs_quad_t cur;            // quadrant shown during this cycle
        cur       = idx;
        next_idx  = idx;
        next_snap = snap;
        next_stb  = sReq[s] && reqOk;
        next_adr  = (sReq[s] && reqOk) ? sAddr[s] : adr;
        if (!reset_n) begin
          next_idx  = `QFBS_FIRST_QUAD;
          next_snap = '0;
          next_stb  = 1'b0;
          next_adr  = '0;
        end else begin
          if (mode == QFBS_POLLED) begin
            // sync marks quadrant 1, the rest follow in order
            next_idx = sSync[s] ? `QFBS_FIRST_QUAD : idx + 2'h1;
          end else if (stb) begin
            next_idx = adr[`QFBS_QUAD_MSB:`QFBS_QUAD_LSB];
          end
          // direct: the bus still shows the quadrant picked before this
          // edge, so back to back strobes never file data under the new one
          cur = (mode == QFBS_POLLED) ? next_idx : idx;
          if (sOe[s]) begin
            next_snap[{cur, 3'h0} +: `QFBS_QUAD_W] = ~sLine[s];
          end
        end
      end

      // collector registers
      always_ff @(posedge clk) begin
        idx  <= next_idx;
        snap <= next_snap;
        stb  <= next_stb;
        adr  <= next_adr;
      end

      assign sSnap[s] = snap;
      assign sStb[s]  = stb;
      assign sAdrO[s] = adr;
    end
  endgenerate

  assign almostEmptySnap           = sSnap[0];
  assign almostFullSnap            = sSnap[1];
  assign link.almostEmptyBusStrobe = sStb[0];
  assign link.almostFullBusStrobe  = sStb[1];
  assign link.readQueueAddress     = sAdrO[0];
  // a full quadrant strobe borrows the write address bus for its cycle;
  // a write selection in that same cycle is not supported
  assign link.writeQueueAddress    = sStb[1] ? sAdrO[1] : wrAddr;

endmodule

`default_nettype wire

// ==== qfbs_assertions.sv ====
// checker for the flag sequencer link, watching the interface signals
// assumes one device at chain position CHAIN_CODE and one shared clock
`timescale 1ns/10ps
`default_nettype none

module qfbs_assertions #(
  parameter logic [2:0] CHAIN_CODE = 3'h0   // device chain position
) (
  input wire logic       clk,
  input wire logic       reset_n,
  input wire logic       flagModeSelect,
  input wire logic       emptyBusSync,
  input wire logic       emptyTokenIn,
  input wire logic       emptyTokenOut,
  input wire logic       fullBusSync,
  input wire logic       fullTokenOut,
  input wire logic       almostEmptyBusOe,
  input wire logic       almostFullBusOe,
  input wire logic       queueFullFlagOe,
  input wire logic       almostEmptyBusStrobe,
  input wire logic       almostFullBusStrobe,
  input wire logic [7:0] readQueueAddress,
  input wire logic [7:0] writeQueueAddress,
  input wire logic       writeAddressEnable,
  input wire logic       serialProgramDoneN
);
  // one domain, so clock and reset are given once
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  // four quadrants between sync pulses
  AST_EMPTY_SYNC_CYCLE: assert property (
    emptyBusSync |=> !emptyBusSync [*3] ##1 emptyBusSync)
    else $error("empty sync period is not four cycles");
  AST_EMPTY_TOKEN_Q4: assert property (
    emptyBusSync |-> ##3 emptyTokenOut)
    else $error("empty token missing with last quadrant");
  AST_TOKEN_RESTART: assert property (
    emptyTokenIn |=> emptyBusSync)
    else $error("token did not restart quadrant one");
  AST_FULL_SYNC_CYCLE: assert property (
    fullBusSync |=> !fullBusSync [*3] ##1 fullBusSync)
    else $error("full sync period is not four cycles");
  AST_FULL_SYNC_POLLED: assert property (
    fullTokenOut |-> $past(fullBusSync, 3) && flagModeSelect)
    else $error("full token not three cycles after sync");
  // only the addressed device takes the shared flag line
  AST_FLAG_OWNER: assert property (
    writeAddressEnable |=> queueFullFlagOe ==
      ($past(writeQueueAddress[7:5]) == CHAIN_CODE))
    else $error("full flag enable does not follow selection");
  AST_FLAG_HOLD: assert property (
    !writeAddressEnable |=> $stable(queueFullFlagOe))
    else $error("full flag enable moved without selection");
  AST_EMPTY_DIRECT_SEL: assert property (
    almostEmptyBusStrobe && !flagModeSelect |=> almostEmptyBusOe ==
      ($past(readQueueAddress[7:5]) == CHAIN_CODE))
    else $error("empty bus enable does not follow strobe");
  AST_FULL_DIRECT_SEL: assert property (
    almostFullBusStrobe && !flagModeSelect |=> almostFullBusOe ==
      ($past(writeQueueAddress[7:5]) == CHAIN_CODE))
    else $error("full bus enable does not follow strobe");
  AST_STROBE_GATED: assert property (
    almostEmptyBusStrobe || almostFullBusStrobe |->
      !serialProgramDoneN && !flagModeSelect)
    else $error("strobe raised before programming or in polled");
  AST_MODE_STABLE: assert property (
    $past(reset_n) |-> $stable(flagModeSelect))
    else $error("flag mode changed outside reset");

  COV_EMPTY_TOKEN: cover property (emptyTokenOut ##1 emptyBusSync);
  COV_FULL_SYNC: cover property (fullBusSync);
  COV_DIRECT_SEL: cover property (almostEmptyBusStrobe ##1 almostEmptyBusOe);
  COV_FLAG_OWNED: cover property (writeAddressEnable ##1 queueFullFlagOe);
endmodule

`default_nettype wire

// ==== tb_queue_flag_bus_sequencer.sv ====
// self-checking bench: controller and device joined by the link
// assumes a single device at chain code 0, acting as chain master
`timescale 1ns/10ps
`default_nettype none
`define QFBS_CHK(got, exp) begin numChecks++; if ((got) !== (exp)) begin \
  errors++; $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp); end end

module tb_queue_flag_bus_sequencer;
  import qfbs_pkg::*;
  localparam logic [31:0] AES = 32'h8421F03C;  // almost-empty status
  localparam logic [31:0] AFS = 32'h5A3C96E1;  // almost-full status
  logic        clk, reset_n, pollMode, programDone, r;
  logic        writeSelReq, fullQuadReq, emptyQuadReq;
  qfbs_addr_t  writeSelAddr, fullQuadAddr, emptyQuadAddr;
  logic [31:0] queueFull, almostEmptySnap, almostFullSnap;
  logic        canWrite, strobeRefused;
  int          errors, numChecks, cycles;

  qfbs_if link ();
  qfbs_device #(.QUEUES(32)) qfbs_device_inst (.clk(clk),
    .reset_n(reset_n), .chainPositionCode(3'h0), .chainMaster(1'b1),
    .programDone(programDone), .almostEmptyStatus(AES),
    .almostFullStatus(AFS), .queueFull(queueFull), .link(link));
  qfbs_controller qfbs_controller_inst (.clk(clk), .reset_n(reset_n),
    .pollMode(pollMode), .writeSelReq(writeSelReq),
    .writeSelAddr(writeSelAddr), .fullQuadReq(fullQuadReq),
    .fullQuadAddr(fullQuadAddr), .emptyQuadReq(emptyQuadReq),
    .emptyQuadAddr(emptyQuadAddr), .canWrite(canWrite),
    .strobeRefused(strobeRefused), .almostEmptySnap(almostEmptySnap),
    .almostFullSnap(almostFullSnap), .link(link));
  qfbs_assertions #(.CHAIN_CODE(3'h0)) qfbs_assertions_inst (.clk(clk),
    .reset_n(reset_n), .flagModeSelect(link.flagModeSelect),
    .emptyBusSync(link.emptyBusSync), .emptyTokenIn(link.emptyTokenIn),
    .emptyTokenOut(link.emptyTokenOut), .fullBusSync(link.fullBusSync),
    .fullTokenOut(link.fullTokenOut),
    .almostEmptyBusOe(link.almostEmptyBusOe),
    .almostFullBusOe(link.almostFullBusOe),
    .queueFullFlagOe(link.queueFullFlagOe),
    .almostEmptyBusStrobe(link.almostEmptyBusStrobe),
    .almostFullBusStrobe(link.almostFullBusStrobe),
    .readQueueAddress(link.readQueueAddress),
    .writeQueueAddress(link.writeQueueAddress),
    .writeAddressEnable(link.writeAddressEnable),
    .serialProgramDoneN(link.serialProgramDoneN));

  // 4 ns clock
  always #2 clk = ~clk;

  // hang guard, the tests need under a hundred cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      errors++;
      tally_and_finish();
    end
  end

  // advance n edges, landing just after the last one
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // mode strap is only taken while reset is held
  task automatic doReset(input logic mode);
    reset_n = 1'b0;
    pollMode = mode;
    step(12);
    reset_n = 1'b1;
  endtask

  // walk five quadrants from sync: wrap, sync and token checked
  task automatic checkPolled(input logic fullSide);
    logic [31:0] st;
    logic [7:0]  ln;
    logic        sy, tk, ti;
    st = fullSide ? AFS : AES;
    for (int i = 0; i < 8; i++) begin
      sy = fullSide ? link.fullBusSync : link.emptyBusSync;
      if (sy === 1'b1) break;
      step(1);
    end
    for (int i = 0; i < 5; i++) begin
      ln = fullSide ? link.almostFullLine : link.almostEmptyLine;
      sy = fullSide ? link.fullBusSync : link.emptyBusSync;
      tk = fullSide ? link.fullTokenOut : link.emptyTokenOut;
      ti = fullSide ? link.fullTokenIn : link.emptyTokenIn;
      `QFBS_CHK(ln, ~st[8*(i%4)+:8])
      `QFBS_CHK(sy, 1'(i % 4 == 0))
      `QFBS_CHK(tk, 1'(i % 4 == 3))
      `QFBS_CHK(ti, 1'(i % 4 == 3))
      step(1);
    end
  endtask

  // one-cycle quadrant request; refusal may show on either edge
  task automatic quadReq(input logic fullSide, input qfbs_addr_t a,
                         output logic refused);
    fullQuadReq = fullSide;
    emptyQuadReq = !fullSide;
    fullQuadAddr = a;
    emptyQuadAddr = a;
    step(1);
    fullQuadReq = 1'b0;
    emptyQuadReq = 1'b0;
    refused = strobeRefused;
    step(1);
    refused = refused | strobeRefused;
  endtask

  // write queue selection, flag valid two edges on
  task automatic selectWrite(input qfbs_addr_t a, input logic expCan);
    writeSelReq = 1'b1;
    writeSelAddr = a;
    step(1);
    writeSelReq = 1'b0;
    step(1);
    `QFBS_CHK(canWrite, expCan)
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", numChecks, errors);
    if (errors == 0 && numChecks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  initial begin
    logic [31:0] st;
    logic [7:0]  ln;
    clk = 1'b0;
    reset_n = 1'b0;
    pollMode = 1'b1;
    programDone = 1'b0;
    writeSelReq = 1'b0;
    fullQuadReq = 1'b0;
    emptyQuadReq = 1'b0;
    writeSelAddr = 8'h00;
    fullQuadAddr = 8'h00;
    emptyQuadAddr = 8'h00;
    queueFull = 32'h00008001;
    // polled: both buses rotate, an empty quadrant strobe request refused
    doReset(1'b1);
    checkPolled(1'b0);
    checkPolled(1'b1);
    step(8);
    `QFBS_CHK(almostEmptySnap, AES)
    `QFBS_CHK(almostFullSnap, AFS)
    quadReq(1'b0, 8'h08, r);
    `QFBS_CHK(r, 1'b1)
    $display("polled test done");
    // direct: refused before programming, then every quadrant
    doReset(1'b0);
    `QFBS_CHK(link.emptyTokenIn, 1'b0)
    quadReq(1'b1, 8'h10, r);
    `QFBS_CHK(r, 1'b1)
    programDone = 1'b1;
    step(2);
    `QFBS_CHK(link.emptyBusSync, 1'b0)
    `QFBS_CHK(link.almostEmptyBusOe, 1'b0)
    for (int q = 0; q < 4; q++) begin
      for (int s = 0; s < 2; s++) begin
        quadReq(1'(s), {3'h0, 2'(q), 3'h0}, r);
        st = s ? AFS : AES;
        `QFBS_CHK(r, 1'b0)
        ln = s ? link.almostFullLine : link.almostEmptyLine;
        `QFBS_CHK(ln, ~st[8*q+:8])
      end
    end
    quadReq(1'b0, 8'hE0, r);
    `QFBS_CHK(link.almostEmptyLine, 8'hFF)
    `QFBS_CHK(almostEmptySnap, AES)
    `QFBS_CHK(almostFullSnap, AFS)
    quadReq(1'b1, 8'h38, r);
    `QFBS_CHK(link.almostFullLine, 8'hFF)
    $display("direct test done");
    // full flag: owned queues, foreign device, status follow
    selectWrite(8'h00, 1'b0);
    selectWrite(8'h01, 1'b1);
    selectWrite(8'h0F, 1'b0);
    selectWrite(8'h40, 1'b1);
    `QFBS_CHK(link.queueFullFlagOe, 1'b0)
    selectWrite(8'h1F, 1'b1);
    queueFull = 32'h80008001;
    step(1);
    `QFBS_CHK(canWrite, 1'b0)
    $display("full flag test done");
    tally_and_finish();
  end
endmodule

`default_nettype wire
